// ---- logic/efs_top.sv ----
// frame status reporting of the ethernet mac: transmit tally and receive status word
`timescale 1ns/1ps
`include "efs_defs.svh"

module efs_top (
   input wire logic clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [31:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // transmit side, to and from the mac transmitter
   input wire logic tx_start_i,
   input wire logic tx_collision_i,
   input wire logic tx_late_collision_i,
   input wire logic tx_done_i,
   output logic tx_retry_o,
   output logic [3:0] tx_collision_tally_o,
   output logic tx_abort_excess_collisions_o,
   output logic tx_abort_late_collision_o,
   // receive side, from the mac receiver
   input wire logic rx_frame_done_i,
   input wire logic [15:0] rx_frame_byte_count_i,
   input wire logic rx_broadcast_i,
   input wire logic rx_multicast_i,
   input wire logic rx_crc_bad_i,
   input wire logic [2:0] rx_dribble_bits_i,
   input wire logic rx_carrier_event_i,
   input wire logic rx_data_violation_i,
   input wire logic rx_data_phase_i,
   input wire logic rx_drained_i,
   // receive error pin from the phy
   input wire logic phy_rx_er_i,
   // fifo and descriptor side
   output logic rx_status_ready_o,
   output logic rx_fifo_has_frame_o,
   output logic rx_buffer_complete_o,
   output logic rx_flush_o,
   output logic desc_we_o,
   output logic [15:0] descriptor_status_index_field_o,
   output logic [15:0] desc_buf_len_o,
   output logic irq_o
);

   efs_pkg::efs_state_t s;
   efs_pkg::efs_state_t next_s;

   // a frame is offered only when no crc, dribble or code error flag is raised
   function automatic logic frame_clean(input logic crc, input logic [2:0] drib,
                                        input logic cv);
      frame_clean = !crc && (drib == 3'h0) && !cv;
   endfunction

   function automatic logic [3:0] tally_view(input efs_pkg::efs_state_t st);
      tally_view = (st.tx_late || st.tx_excess) ? st.tx_tally : 4'h0;
   endfunction

   logic [31:0] new_status;
   logic clean;
   logic cv_now;
   logic [1:0] irq_set;

   always_comb begin
      next_s = s;
      next_s.tx_retry = 1'b0;
      next_s.flush = 1'b0;
      next_s.desc_we = 1'b0;
      next_s.buf_complete = 1'b0;
      next_s.rdata = `EFS_ZERO32;
      irq_set = 2'b00;

      // receive error pin, two flops before use
      next_s.er_s1 = phy_rx_er_i;
      next_s.er_s2 = s.er_s1;

      // ---------------- transmit ----------------
      case (s.tx_state)
         efs_pkg::EFS_TX_IDLE,
         efs_pkg::EFS_TX_DONE: begin
            if (tx_start_i) begin
               next_s.tx_tally = 4'h0;
               next_s.tx_excess = 1'b0;
               next_s.tx_late = 1'b0;
               next_s.tx_state = efs_pkg::EFS_TX_SEND;
            end
         end
         efs_pkg::EFS_TX_SEND: begin
            if (tx_late_collision_i) begin
               next_s.tx_late = 1'b1;
               if (s.tx_tally != `EFS_TALLY_MAX) begin
                  next_s.tx_tally = s.tx_tally + 4'h1;
               end
               next_s.tx_state = efs_pkg::EFS_TX_DONE;
               irq_set[`EFS_IRQ_TX_ABORT_BIT] = 1'b1;
            end else if (tx_collision_i) begin
               if (s.tx_tally != `EFS_TALLY_MAX) begin
                  next_s.tx_tally = s.tx_tally + 4'h1;
               end
               if (s.tx_tally >= s.retry_limit) begin
                  next_s.tx_excess = 1'b1;
                  next_s.tx_state = efs_pkg::EFS_TX_DONE;
                  irq_set[`EFS_IRQ_TX_ABORT_BIT] = 1'b1;
               end else begin
                  next_s.tx_retry = 1'b1;
               end
            end else if (tx_done_i) begin
               next_s.tx_state = efs_pkg::EFS_TX_DONE;
            end
         end
         default: begin
            next_s.tx_state = efs_pkg::EFS_TX_IDLE;
         end
      endcase

      // ---------------- receive ----------------
      // error seen only inside data phase
      cv_now = s.er_s2 && rx_data_phase_i;
      clean = frame_clean(rx_crc_bad_i, rx_dribble_bits_i, s.cv_pend || cv_now);

      new_status = `EFS_ZERO32;
      new_status[`EFS_RX_SIZE_HI:`EFS_RX_SIZE_LO] = rx_frame_byte_count_i;
      new_status[`EFS_RX_CE_BIT] = s.ce_pend;
      new_status[`EFS_RX_DV_BIT] = s.dv_pend;
      new_status[`EFS_RX_OK_BIT] = clean;
      new_status[`EFS_RX_BC_BIT] = rx_broadcast_i;
      new_status[`EFS_RX_MC_BIT] = rx_multicast_i;
      new_status[`EFS_RX_CRC_BIT] = rx_crc_bad_i;
      // dribble flag, one to seven bits
      new_status[`EFS_RX_DR_BIT] = (rx_dribble_bits_i != 3'h0);
      new_status[`EFS_RX_CV_BIT] = s.cv_pend || cv_now;

      // history flags; a carrier or violation event in the completing cycle counts toward the next frame, a code error toward this one
      if (rx_frame_done_i) begin
         next_s.ce_pend = rx_carrier_event_i;
         next_s.dv_pend = rx_data_violation_i;
         next_s.cv_pend = 1'b0;
      end else begin
         next_s.ce_pend = s.ce_pend || rx_carrier_event_i;
         next_s.dv_pend = s.dv_pend || rx_data_violation_i;
         next_s.cv_pend = s.cv_pend || cv_now;
      end

      // drained frame drops ready; a clean frame completing now wins over it
      if (rx_drained_i) begin
         next_s.rx_ready = 1'b0;
         next_s.fifo_has = 1'b0;
      end

      if (rx_frame_done_i) begin
         next_s.rx_status = new_status;
         next_s.buf_complete = 1'b1;
         irq_set[`EFS_IRQ_RX_DONE_BIT] = 1'b1;
         if (clean) begin
            next_s.rx_ready = 1'b1;
            next_s.fifo_has = 1'b1;
         end else begin
            next_s.flush = 1'b1;
         end
         if (s.dma_mode) begin
            next_s.desc_we = 1'b1;
            next_s.desc_status_index = new_status[15:0];
            next_s.desc_buf_len = rx_frame_byte_count_i;
         end
      end

      // ---------------- register port ----------------
      if (reg_wr_i) begin
         case (reg_addr_i)
            `EFS_ADDR_CONTROL: begin
               next_s.dma_mode = reg_wdata_i[`EFS_CTL_DMA_BIT];
               next_s.retry_limit = reg_wdata_i[`EFS_CTL_RETRY_HI:`EFS_CTL_RETRY_LO];
            end
            `EFS_ADDR_IRQ_STATUS: begin
               next_s.irq_stat = s.irq_stat & ~reg_wdata_i[1:0];
            end
            `EFS_ADDR_IRQ_MASK: begin
               next_s.irq_mask = reg_wdata_i[1:0];
            end
            // rx, tx and general status registers are read only; writes ignored
            default: begin
            end
         endcase
      end
      // new events win over a clear in the same cycle
      next_s.irq_stat = next_s.irq_stat | irq_set;

      if (reg_rd_i) begin
         case (reg_addr_i)
            `EFS_ADDR_RX_STATUS: begin
               next_s.rdata = s.rx_status;
            end
            `EFS_ADDR_TX_STATUS: begin
               next_s.rdata[`EFS_TX_TALLY_HI:`EFS_TX_TALLY_LO] = tally_view(s);
               next_s.rdata[`EFS_TX_LATE_BIT] = s.tx_late;
               next_s.rdata[`EFS_TX_EXCESS_BIT] = s.tx_excess;
            end
            `EFS_ADDR_CONTROL: begin
               next_s.rdata[`EFS_CTL_DMA_BIT] = s.dma_mode;
               next_s.rdata[`EFS_CTL_RETRY_HI:`EFS_CTL_RETRY_LO] = s.retry_limit;
            end
            `EFS_ADDR_GEN_STATUS: begin
               next_s.rdata[`EFS_GEN_READY_BIT] = s.rx_ready;
               next_s.rdata[`EFS_GEN_FIFO_BIT] = s.fifo_has;
            end
            `EFS_ADDR_IRQ_STATUS: begin
               next_s.rdata[1:0] = s.irq_stat;
            end
            `EFS_ADDR_IRQ_MASK: begin
               next_s.rdata[1:0] = s.irq_mask;
            end
            default: begin
               next_s.rdata = `EFS_ZERO32;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.tx_state <= efs_pkg::EFS_TX_IDLE;
         s.retry_limit <= `EFS_RETRY_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata_o = s.rdata;
   assign tx_retry_o = s.tx_retry;
   assign tx_collision_tally_o = tally_view(s);
   assign tx_abort_excess_collisions_o = s.tx_excess;
   assign tx_abort_late_collision_o = s.tx_late;
   assign rx_status_ready_o = s.rx_ready;
   assign rx_fifo_has_frame_o = s.fifo_has;
   assign rx_buffer_complete_o = s.buf_complete;
   assign rx_flush_o = s.flush;
   assign desc_we_o = s.desc_we;
   assign descriptor_status_index_field_o = s.desc_status_index;
   assign desc_buf_len_o = s.desc_buf_len;
   // level interrupt while an unmasked event is pending
   assign irq_o = |(s.irq_stat & s.irq_mask);

endmodule // efs_top

// ---- logic/efs_defs.svh ----
// offsets, field positions, reset values and counts of the frame status block
`ifndef EFS_DEFS_SVH
`define EFS_DEFS_SVH

`define EFS_ADDR_RX_STATUS 32'hff80_0014
`define EFS_ADDR_TX_STATUS 32'hff80_0018
`define EFS_ADDR_CONTROL 32'hff80_001c
`define EFS_ADDR_GEN_STATUS 32'hff80_0020
`define EFS_ADDR_IRQ_STATUS 32'hff80_0024
`define EFS_ADDR_IRQ_MASK 32'hff80_0028

`define EFS_RX_SIZE_HI 31
`define EFS_RX_SIZE_LO 16
`define EFS_RX_CE_BIT 15
`define EFS_RX_DV_BIT 14
`define EFS_RX_OK_BIT 13
`define EFS_RX_BC_BIT 12
`define EFS_RX_MC_BIT 11
`define EFS_RX_CRC_BIT 10
`define EFS_RX_DR_BIT 9
`define EFS_RX_CV_BIT 8

`define EFS_TX_TALLY_HI 3
`define EFS_TX_TALLY_LO 0
`define EFS_TX_LATE_BIT 11
`define EFS_TX_EXCESS_BIT 12

`define EFS_CTL_DMA_BIT 0
`define EFS_CTL_RETRY_HI 7
`define EFS_CTL_RETRY_LO 4

`define EFS_GEN_READY_BIT 0
`define EFS_GEN_FIFO_BIT 1

`define EFS_IRQ_RX_DONE_BIT 0
`define EFS_IRQ_TX_ABORT_BIT 1

`define EFS_RETRY_RESET 4'hf
`define EFS_TALLY_MAX 4'hf
`define EFS_ZERO32 32'h0000_0000
`define EFS_ZERO16 16'h0000

`endif

// ---- logic/efs_pkg.sv ----
// types of the frame status block
package efs_pkg;

   typedef enum logic [1:0] {
      EFS_TX_IDLE = 2'b00,
      EFS_TX_SEND = 2'b01,
      EFS_TX_DONE = 2'b10
   } efs_tx_state_t;

   typedef struct packed {
      efs_tx_state_t tx_state;
      logic [3:0] tx_tally;
      logic tx_excess;
      logic tx_late;
      logic tx_retry;
      logic [3:0] retry_limit;
      logic dma_mode;
      logic [31:0] rx_status;
      logic ce_pend;
      logic dv_pend;
      logic cv_pend;
      logic rx_ready;
      logic fifo_has;
      logic buf_complete;
      logic flush;
      logic desc_we;
      logic [15:0] desc_status_index;
      logic [15:0] desc_buf_len;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic [31:0] rdata;
      logic er_s1;
      logic er_s2;
   } efs_state_t;

endpackage

// ---- tb/efs_props.sv ----
// assertions on the ports of the frame status block
`timescale 1ns/1ps
module efs_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic rx_frame_done_i,
   input wire logic rx_crc_bad_i,
   input wire logic [2:0] rx_dribble_bits_i,
   input wire logic [15:0] rx_frame_byte_count_i,
   input wire logic rx_drained_i,
   input wire logic rx_buffer_complete_o,
   input wire logic rx_flush_o,
   input wire logic rx_status_ready_o,
   input wire logic rx_fifo_has_frame_o,
   input wire logic desc_we_o,
   input wire logic [15:0] desc_buf_len_o,
   input wire logic [15:0] descriptor_status_index_field_o,
   input wire logic [3:0] tx_collision_tally_o,
   input wire logic tx_abort_excess_collisions_o,
   input wire logic tx_abort_late_collision_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_tally_zero: assert property (
      !(tx_abort_late_collision_o || tx_abort_excess_collisions_o) |-> tx_collision_tally_o == 4'h0)
      else $error("tally shown without abort");
   a_excess_tally: assert property (
      $rose(tx_abort_excess_collisions_o) |-> tx_collision_tally_o != 4'h0)
      else $error("abort with empty tally");
   a_done_complete: assert property (
      rx_frame_done_i |=> rx_buffer_complete_o) else $error("no buffer complete");
   a_crc_flush: assert property (
      rx_frame_done_i && rx_crc_bad_i |=> rx_flush_o) else $error("crc frame kept");
   a_dribble_flush: assert property (
      rx_frame_done_i && rx_dribble_bits_i != 3'h0 |=> rx_flush_o) else $error("dribble kept");
   a_good_ready: assert property (
      rx_buffer_complete_o && !rx_flush_o |-> rx_status_ready_o && rx_fifo_has_frame_o)
      else $error("good frame not offered");
   a_drain_drop: assert property (
      rx_drained_i && !rx_frame_done_i |=> !rx_status_ready_o && !rx_fifo_has_frame_o)
      else $error("ready after drain");
   a_desc_len: assert property (
      desc_we_o |-> desc_buf_len_o == $past(rx_frame_byte_count_i)) else $error("bad length");
   a_desc_index: assert property (
      desc_we_o |-> descriptor_status_index_field_o[13] != rx_flush_o) else $error("bad index");
endmodule // efs_props
bind efs_top efs_props i_efs_props (.*);

// ---- tb/efs_far_model.sv ----
// phy and dma side: drains offered frames and drives the receive error pin
`timescale 1ns/1ps
module efs_far_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic rx_status_ready_i,
   input wire logic slow_i,
   input wire logic er_req_i,
   output logic rx_drained_o,
   output logic phy_rx_er_o
);
   logic [3:0] wait_cnt;
   // slow mode leaves room for software to poll ready first
   always_ff @(posedge clk_i) begin
      rx_drained_o <= 1'b0;
      phy_rx_er_o <= er_req_i;
      if (rst_i || !rx_status_ready_i || rx_drained_o) begin
         wait_cnt <= 4'h0;
      end else if (wait_cnt == (slow_i ? 4'h9 : 4'h1)) begin
         rx_drained_o <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule // efs_far_model

// ---- tb/tb_efs_top.sv ----
// testbench of the frame status block
`timescale 1ns/1ps
`include "efs_defs.svh"
module tb_efs_top;
   logic clk_i, rst_i, reg_wr_i, reg_rd_i, rd_q, er_req, slow;
   logic [31:0] reg_addr_i, reg_wdata_i, reg_rdata_o, r, exp_q[$];
   logic tx_start_i, tx_collision_i, tx_late_collision_i, tx_retry_o;
   logic tx_done_i, tx_abort_excess_collisions_o, tx_abort_late_collision_o;
   logic [3:0] tx_collision_tally_o;
   logic rx_frame_done_i, rx_broadcast_i, rx_multicast_i, rx_crc_bad_i, rx_drained_i;
   logic rx_carrier_event_i, rx_data_violation_i, rx_data_phase_i, phy_rx_er_i;
   logic [15:0] rx_frame_byte_count_i, descriptor_status_index_field_o, desc_buf_len_o;
   logic [2:0] rx_dribble_bits_i;
   logic rx_status_ready_o, rx_fifo_has_frame_o, rx_buffer_complete_o, rx_flush_o;
   logic desc_we_o, irq_o;
   integer fails = 0, check_count = 0, seed = 53137;
   efs_top i_efs_top (.*);
   efs_far_model i_efs_far_model (.clk_i(clk_i), .rst_i(rst_i), .rx_status_ready_i(rx_status_ready_o),
      .slow_i(slow), .er_req_i(er_req), .rx_drained_o(rx_drained_i), .phy_rx_er_o(phy_rx_er_i));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task rd(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      @(posedge clk_i);
      {reg_rd_i, reg_addr_i} <= {1'b1, a};
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   always @(posedge clk_i) rd_q <= reg_rd_i;
   always @(negedge clk_i) if (rd_q === 1'b1) check(reg_rdata_o, exp_q.pop_front());
   task txp(input logic [2:0] v);
      @(posedge clk_i);
      {tx_start_i, tx_collision_i, tx_late_collision_i} <= v;
      @(posedge clk_i);
      {tx_start_i, tx_collision_i, tx_late_collision_i} <= 3'h0;
   endtask
   // f holds broadcast, multicast, crc; h holds carrier, violation, code error
   task frame(input logic [15:0] n, input logic [2:0] f, input logic [2:0] dr,
      input logic [2:0] h);
      logic ok;
      logic [31:0] s;
      ok = !f[0] && dr == 3'h0 && !h[0];
      s = {n, h[2:1], ok, f, dr != 3'h0, h[0], 8'h00};
      @(posedge clk_i);
      {rx_frame_done_i, rx_frame_byte_count_i, rx_dribble_bits_i} <= {1'b1, n, dr};
      {rx_broadcast_i, rx_multicast_i, rx_crc_bad_i} <= f;
      @(posedge clk_i);
      rx_frame_done_i <= 1'b0;
      rd(`EFS_ADDR_RX_STATUS, s);
      check({16'h0, descriptor_status_index_field_o}, {16'h0, s[15:0]});
      check({16'h0, desc_buf_len_o}, {16'h0, n});
      rd(`EFS_ADDR_GEN_STATUS, {30'h0, ok & slow, ok & slow});
      // let the far side drain before the next frame, so its drain cannot hit that one
      repeat (8) @(posedge clk_i);
   endtask
   initial begin
      {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, er_req, slow} = '0;
      {tx_start_i, tx_collision_i, tx_late_collision_i, tx_done_i} = 4'h0;
      {rx_frame_done_i, rx_broadcast_i, rx_multicast_i, rx_crc_bad_i} = 4'h0;
      {rx_carrier_event_i, rx_data_violation_i, rx_data_phase_i} = 3'h0;
      {rx_frame_byte_count_i, rx_dribble_bits_i} = '0;
      rst_i = 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wr(`EFS_ADDR_RX_STATUS, 32'hffff_ffff);
      rd(`EFS_ADDR_RX_STATUS, 32'h0000_0000);
      rd(`EFS_ADDR_TX_STATUS, 32'h0000_0000);
      rd(`EFS_ADDR_CONTROL, 32'h0000_00f0);
      rd(32'hff80_0030, 32'h0000_0000);
      wr(`EFS_ADDR_CONTROL, 32'h0000_0021);
      wr(`EFS_ADDR_IRQ_MASK, 32'h0000_0002);
      txp(3'h4);
      txp(3'h2);
      @(negedge clk_i);
      check({28'h0, tx_collision_tally_o}, 32'h0000_0000);
      check({31'h0, tx_retry_o}, 32'h0000_0001);
      txp(3'h2);
      txp(3'h2);
      rd(`EFS_ADDR_TX_STATUS, 32'h0000_1003);
      check({31'h0, irq_o}, 32'h0000_0001);
      wr(`EFS_ADDR_IRQ_STATUS, 32'h0000_0003);
      @(negedge clk_i);
      check({31'h0, irq_o}, 32'h0000_0000);
      txp(3'h4);
      txp(3'h2);
      txp(3'h1);
      rd(`EFS_ADDR_TX_STATUS, 32'h0000_0802);
      slow <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         frame(r[15:0], i[2:0], (i == 5) ? 3'h7 : ((i == 6) ? 3'h1 : 3'h0), 3'h0);
      end
      @(posedge clk_i);
      {rx_carrier_event_i, rx_data_violation_i} <= 2'h3;
      @(posedge clk_i);
      {rx_carrier_event_i, rx_data_violation_i} <= 2'h0;
      frame(16'h0040, 3'h0, 3'h0, 3'h6);
      slow <= 1'b0;
      frame(16'h05ee, 3'h4, 3'h0, 3'h0);
      @(posedge clk_i);
      {rx_data_phase_i, er_req} <= 2'h3;
      @(posedge clk_i);
      er_req <= 1'b0;
      repeat (4) @(posedge clk_i);
      frame(16'h0100, 3'h0, 3'h0, 3'h1);
      rx_data_phase_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      finish_test;
   end
   initial begin
      #50000;
      fails++;
      finish_test;
   end
endmodule // tb_efs_top
